// ### hw/meter_settings.sv
// Purpose: min/max hold, display clamp, lock, access code and bias settings
// Assumes: pv_sample comes from logic on clk_sys; contacts are raw pins
// Notes: registers over Avalon-MM, one wait cycle for every access
`timescale 1ns/1ns

// Summary of operation
// - Hold smallest process value seen
// - Hold largest process value seen
// - Extremes live only while powered
// - Extremes start at 100.0% and 0.0%
// - Mode off ignores both contacts
// - Mode one: contact a clears both
// - Mode two: a for minimum, b maximum
// - Display not above upper clamp when sampled
// - Display not below lower clamp when sampled
// - Lock refuses every other setting write
// - Correct access code opens control settings
// - Restore loads defaults, then self-clears
// - Quick view slots: off or 1..1299
// - Knees ordered within range ends
// - Offsets limited to +-100.0%
// - Scale limits ordered, point 0..3
// - Bias interpolated between knee offsets
// - Open sensor forces range high or low
module meter_settings
    import meter_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] pv_sample,
    input wire logic pv_valid,
    input wire logic sensor_open,
    input wire logic contact_a,
    input wire logic contact_b,
    output val_t display_value,
    output val_t control_value,
    output val_t lowest_value_hold,
    output val_t highest_value_hold,
    output logic [15:0] quick_view_slot_a,
    output logic [15:0] quick_view_slot_b
);
    settings_t cfg; // Live settings
    settings_t next_cfg; // Settings after a committed write
    logic wr_ok; // Write passes range, lock and code checks
    logic granted; // Access code accepted
    logic restore_pend; // Restore requested, defaults next cycle
    logic [1:0] contact_meta; // First synchroniser stage
    logic [1:0] contact_sync; // Contacts safe to use
    logic pv_seen; // Control value was refreshed last cycle
    logic commit; // Bus write takes effect this edge
    logic [31:0] rd_word; // Read mux result
    val_t eff_pv; // Sample after open sensor policy
    val_t bias; // Interpolated offset
    logic signed [31:0] biased; // Sample plus offset, wide
    val_t sat_ctl; // Control value inside extreme span
    logic clr_lo, clr_hi, rec_lo, rec_hi; // Contact decoded actions
    val_t ws; // Write data as signed value

    // Clamp a wide value into a window
    function automatic val_t sat(logic signed [31:0] v, val_t lo, val_t hi);
        if (v < 32'(lo))
            return lo;
        if (v > 32'(hi))
            return hi;
        return val_t'(v);
    endfunction

    // Piecewise linear offset over range low, three knees, range high
    function automatic val_t bias_at(val_t pv, settings_t s);
        logic signed [31:0] x0, x1, y0, y1, num;
        x0 = 32'sd0;
        x1 = 32'($signed(s.knee[0]));
        y0 = 32'($signed(s.offs[0]));
        y1 = 32'($signed(s.offs[1]));
        for (int i = 0; i < 3; i++)
        begin
            // Move to the next segment once past its knee
            if (pv > $signed(s.knee[i]))
            begin
                x0 = 32'($signed(s.knee[i]));
                // Index wraps so no knee past the third is ever read
                x1 = (i == 2) ? 32'(PCT_100) : 32'($signed(s.knee[(i + 1) % 3]));
                y0 = 32'($signed(s.offs[i + 1]));
                y1 = 32'($signed(s.offs[i + 2]));
            end
        end
        // Zero-width segment: no slope, take the far offset
        if (x1 == x0)
            return val_t'(y1);
        num = (32'(pv) - x0) * (y1 - y0);
        return sat(y0 + num / (x1 - x0), VAL_MIN, VAL_MAX);
    endfunction

    // Contact synchroniser, two stages before any use
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            contact_meta <= 2'h3;
            contact_sync <= 2'h3;
        end
        else
        begin
            contact_meta <= {contact_b, contact_a};
            contact_sync <= contact_meta;
        end
    end

    // Bus handshake: one wait cycle, answer stands one cycle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            avs_waitrequest <= 1'b1;
        else if ((avs_read || avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    assign commit = avs_write && !avs_waitrequest;
    assign ws = $signed(avs_writedata[15:0]);

    // Read mux, unmapped words read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (avs_address)
            A_STATUS: rd_word = {29'h0, cfg.lock, sensor_open, granted};
            A_LOWEST: rd_word = 32'(lowest_value_hold);
            A_HIGHEST: rd_word = 32'(highest_value_hold);
            A_DISPLAY: rd_word = 32'(display_value);
            A_CONTROL: rd_word = 32'(control_value);
            A_LOCK: rd_word = {31'h0, cfg.lock};
            A_ACCESS: rd_word = {16'h0, cfg.access_code};
            A_MODE: rd_word = {30'h0, cfg.contact_mode};
            A_CLAMP_HI: rd_word = 32'(cfg.clamp_high);
            A_CLAMP_LO: rd_word = 32'(cfg.clamp_low);
            A_SLOT_A: rd_word = {16'h0, cfg.slot_a};
            A_SLOT_B: rd_word = {16'h0, cfg.slot_b};
            A_RESTORE: rd_word = {31'h0, restore_pend};
            A_SCALE_TOP: rd_word = 32'(cfg.scale_top);
            A_SCALE_BOT: rd_word = 32'(cfg.scale_bottom);
            A_POINT: rd_word = {30'h0, cfg.point_place};
            A_POLICY: rd_word = {30'h0, cfg.open_policy};
            7'h48, 7'h4c, 7'h50: rd_word = 32'($signed(cfg.knee[avs_address[3:2] - 2'h2]));
            7'h54, 7'h58, 7'h5c, 7'h60, 7'h64:
                rd_word = 32'($signed(cfg.offs[3'((avs_address - A_OFFS0) >> 2)]));
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read data prepared in the wait cycle, stands at the answer edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= rd_word;
    end

    // Write decode with range checks; bad values are dropped silently
    always_comb
    begin
        next_cfg = cfg;
        wr_ok = 1'b0;
        unique case (avs_address)
            A_LOCK:
            begin
                next_cfg.lock = avs_writedata[0];
                wr_ok = 1'b1;
            end
            A_ACCESS:
            begin
                next_cfg.access_code = avs_writedata[15:0];
                wr_ok = avs_writedata[15:0] <= CODE_MAX;
            end
            A_MODE:
            begin
                next_cfg.contact_mode = avs_writedata[1:0];
                wr_ok = avs_writedata[1:0] <= MODE_TWO;
            end
            A_CLAMP_HI:
            begin
                next_cfg.clamp_high = ws;
                wr_ok = ws <= PV_CEIL && ws > cfg.clamp_low;
            end
            A_CLAMP_LO:
            begin
                next_cfg.clamp_low = ws;
                wr_ok = ws >= PV_FLOOR && ws < cfg.clamp_high;
            end
            A_SLOT_A:
            begin
                next_cfg.slot_a = avs_writedata[15:0];
                wr_ok = avs_writedata[15:0] <= SLOT_MAX;
            end
            A_SLOT_B:
            begin
                next_cfg.slot_b = avs_writedata[15:0];
                wr_ok = avs_writedata[15:0] <= SLOT_MAX;
            end
            // Restore is a strobe, nothing stored here
            A_RESTORE: wr_ok = avs_writedata[0];
            A_SCALE_TOP:
            begin
                next_cfg.scale_top = ws;
                wr_ok = ws <= SCALE_MAX && ws > cfg.scale_bottom;
            end
            A_SCALE_BOT:
            begin
                next_cfg.scale_bottom = ws;
                wr_ok = ws >= SCALE_MIN && ws < cfg.scale_top;
            end
            A_POINT:
            begin
                next_cfg.point_place = avs_writedata[1:0];
                wr_ok = 1'b1;
            end
            A_POLICY:
            begin
                next_cfg.open_policy = avs_writedata[1:0];
                wr_ok = avs_writedata[1:0] <= POL_DOWN;
            end
            7'h48, 7'h4c, 7'h50:
            begin
                next_cfg.knee[avs_address[3:2] - 2'h2] = ws;
                wr_ok = PCT_0 <= $signed(next_cfg.knee[0])
                    && $signed(next_cfg.knee[0]) <= $signed(next_cfg.knee[1])
                    && $signed(next_cfg.knee[1]) <= $signed(next_cfg.knee[2])
                    && $signed(next_cfg.knee[2]) <= PCT_100;
            end
            7'h54, 7'h58, 7'h5c, 7'h60, 7'h64:
            begin
                next_cfg.offs[3'((avs_address - A_OFFS0) >> 2)] = ws;
                wr_ok = ws >= OFFS_MIN && ws <= -OFFS_MIN;
            end
            default: wr_ok = 1'b0;
        endcase
        if (cfg.lock && avs_address != A_LOCK)
            wr_ok = 1'b0;
        if (!granted && avs_address < A_SCALE_TOP)
            wr_ok = 1'b0;
    end

    // Settings store and restore; restore wins over a same-cycle write
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg <= SET_DEFAULTS;
            restore_pend <= 1'b0;
        end
        else if (restore_pend)
        begin
            cfg <= SET_DEFAULTS;
            restore_pend <= 1'b0;
        end
        else if (commit && wr_ok)
        begin
            cfg <= next_cfg;
            restore_pend <= avs_address == A_RESTORE;
        end
    end

    // Code prompt: a match opens, a miss closes
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            granted <= 1'b0;
        else if (commit && avs_address == A_PROMPT)
            granted <= avs_writedata[15:0] == cfg.access_code;
    end

    assign eff_pv = !sensor_open ? $signed(pv_sample) :
        cfg.open_policy == POL_UP ? PCT_100 :
        cfg.open_policy == POL_DOWN ? PCT_0 : $signed(pv_sample);
    assign bias = bias_at(eff_pv, cfg);
    assign biased = 32'(eff_pv) + 32'(bias);

    // Value path: control unclamped, display clamped
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            control_value <= PCT_0;
            display_value <= PCT_0;
            pv_seen <= 1'b0;
        end
        else
        begin
            pv_seen <= pv_valid;
            if (pv_valid)
            begin
                control_value <= sat(biased, VAL_MIN, VAL_MAX);
                display_value <= sat(biased, cfg.clamp_low, cfg.clamp_high);
            end
        end
    end

    assign sat_ctl = sat(32'(control_value), PV_FLOOR, PV_CEIL);

    always_comb
    begin
        clr_lo = 1'b0;
        clr_hi = 1'b0;
        unique case (cfg.contact_mode)
            MODE_ONE:
            begin
                clr_lo = !contact_sync[0];
                clr_hi = !contact_sync[0];
            end
            MODE_TWO:
            begin
                clr_lo = !contact_sync[0];
                clr_hi = !contact_sync[1];
            end
            default:
            begin
                clr_lo = 1'b0;
                clr_hi = 1'b0;
            end
        endcase
        rec_lo = !clr_lo;
        rec_hi = !clr_hi;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowest_value_hold <= PCT_100;
            highest_value_hold <= PCT_0;
        end
        else
        begin
            if (clr_lo)
                lowest_value_hold <= sat_ctl;
            else if (pv_seen && rec_lo && sat_ctl < lowest_value_hold)
                lowest_value_hold <= sat_ctl;
            if (clr_hi)
                highest_value_hold <= sat_ctl;
            else if (pv_seen && rec_hi && sat_ctl > highest_value_hold)
                highest_value_hold <= sat_ctl;
        end
    end

    // Quick view slots out to the operation display
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            quick_view_slot_a <= 16'h0000;
            quick_view_slot_b <= 16'h0000;
        end
        else
        begin
            quick_view_slot_a <= cfg.slot_a;
            quick_view_slot_b <= cfg.slot_b;
        end
    end

    sequence s_restore_req;
        commit && wr_ok && !restore_pend && avs_address == A_RESTORE;
    endsequence
    sequence s_restore_done;
        restore_pend ##1 (cfg == SET_DEFAULTS && !restore_pend);
    endsequence

    property p_lowest;
        @(posedge clk_sys) disable iff (!arst_n)
        pv_seen && rec_lo && sat_ctl < lowest_value_hold |=> lowest_value_hold == $past(sat_ctl);
    endproperty
    a_lowest: assert property (p_lowest) else $error("minimum not captured");
    property p_highest;
        @(posedge clk_sys) disable iff (!arst_n)
        pv_seen && rec_hi && sat_ctl > highest_value_hold |=> highest_value_hold == $past(sat_ctl);
    endproperty
    a_highest: assert property (p_highest) else $error("maximum not captured");
    property p_span;
        @(posedge clk_sys) disable iff (!arst_n)
        lowest_value_hold >= PV_FLOOR && highest_value_hold <= PV_CEIL;
    endproperty
    a_span: assert property (p_span) else $error("extreme out of span");
    property p_mode_off;
        @(posedge clk_sys) disable iff (!arst_n)
        cfg.contact_mode == MODE_OFF && !pv_seen ##1 !pv_seen |-> $stable(lowest_value_hold);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("contact acted in off mode");
    property p_mode_one;
        @(posedge clk_sys) disable iff (!arst_n)
        cfg.contact_mode == MODE_ONE && !contact_sync[0]
        |=> lowest_value_hold == $past(sat_ctl) && highest_value_hold == $past(sat_ctl);
    endproperty
    a_mode_one: assert property (p_mode_one) else $error("mode one clear failed");
    property p_mode_two;
        @(posedge clk_sys) disable iff (!arst_n)
        cfg.contact_mode == MODE_TWO && !contact_sync[1] |=> highest_value_hold == $past(sat_ctl);
    endproperty
    a_mode_two: assert property (p_mode_two) else $error("mode two clear failed");
    property p_clamp;
        @(posedge clk_sys) disable iff (!arst_n)
        pv_valid |=> display_value <= $past(cfg.clamp_high) && display_value >= $past(cfg.clamp_low);
    endproperty
    a_clamp: assert property (p_clamp) else $error("display outside clamp");
    property p_lock;
        @(posedge clk_sys) disable iff (!arst_n)
        commit && cfg.lock && avs_address != A_LOCK && !restore_pend |=> $stable(cfg);
    endproperty
    a_lock: assert property (p_lock) else $error("setting changed while locked");
    property p_code;
        @(posedge clk_sys) disable iff (!arst_n)
        commit && avs_address == A_PROMPT && avs_writedata[15:0] != cfg.access_code |=> !granted;
    endproperty
    a_code: assert property (p_code) else $error("wrong code opened access");
    property p_restore;
        @(posedge clk_sys) disable iff (!arst_n)
        s_restore_req |=> s_restore_done;
    endproperty
    a_restore: assert property (p_restore) else $error("restore sequence failed");
endmodule

// ### hw/meter_pkg.sv
// Purpose: constants, types and defaults shared by the meter settings block
// Assumes: process values in tenths of a percent of range (1000 = 100.0%)
// Notes: byte offsets of the register bank, one 32-bit word each
package meter_pkg;
    // Register byte offsets
    localparam logic [6:0] A_STATUS = 7'h00;
    localparam logic [6:0] A_LOWEST = 7'h04;
    localparam logic [6:0] A_HIGHEST = 7'h08;
    localparam logic [6:0] A_DISPLAY = 7'h0c;
    localparam logic [6:0] A_CONTROL = 7'h10;
    localparam logic [6:0] A_LOCK = 7'h14;
    localparam logic [6:0] A_PROMPT = 7'h18;
    localparam logic [6:0] A_ACCESS = 7'h1c;
    localparam logic [6:0] A_MODE = 7'h20;
    localparam logic [6:0] A_CLAMP_HI = 7'h24;
    localparam logic [6:0] A_CLAMP_LO = 7'h28;
    localparam logic [6:0] A_SLOT_A = 7'h2c;
    localparam logic [6:0] A_SLOT_B = 7'h30;
    localparam logic [6:0] A_RESTORE = 7'h34;
    localparam logic [6:0] A_SCALE_TOP = 7'h38;
    localparam logic [6:0] A_SCALE_BOT = 7'h3c;
    localparam logic [6:0] A_POINT = 7'h40;
    localparam logic [6:0] A_POLICY = 7'h44;
    localparam logic [6:0] A_KNEE0 = 7'h48;
    localparam logic [6:0] A_OFFS0 = 7'h54;
    // Status bit positions
    localparam int STAT_GRANTED = 0;
    localparam int STAT_OPEN = 1;
    localparam int STAT_LOCK = 2;
    // Value limits in tenths of a percent
    typedef logic signed [15:0] val_t;
    localparam val_t PCT_0 = 16'h0000;
    localparam val_t PCT_100 = 16'h03e8;
    localparam val_t PV_FLOOR = 16'hffce;
    localparam val_t PV_CEIL = 16'h041a;
    localparam val_t OFFS_MIN = 16'hfc18;
    localparam val_t VAL_MIN = 16'h8000;
    localparam val_t VAL_MAX = 16'h7fff;
    localparam val_t SCALE_MIN = 16'hf831;
    localparam val_t SCALE_MAX = 16'h270f;
    localparam logic [15:0] CODE_MAX = 16'h270f;
    localparam logic [15:0] SLOT_MAX = 16'h0513;
    // Contact modes and open sensor policies
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ONE = 2'h1;
    localparam logic [1:0] MODE_TWO = 2'h2;
    localparam logic [1:0] POL_OFF = 2'h0;
    localparam logic [1:0] POL_UP = 2'h1;
    localparam logic [1:0] POL_DOWN = 2'h2;
    // All settable values, restored as one word
    typedef struct packed {
        logic lock;
        logic [15:0] access_code;
        logic [1:0] contact_mode;
        val_t clamp_high;
        val_t clamp_low;
        logic [15:0] slot_a;
        logic [15:0] slot_b;
        val_t scale_top;
        val_t scale_bottom;
        logic [1:0] point_place;
        logic [1:0] open_policy;
        logic [2:0][15:0] knee;
        logic [4:0][15:0] offs;
    } settings_t;
    localparam settings_t SET_DEFAULTS = '{
        lock: 1'b0, access_code: 16'h0000, contact_mode: MODE_OFF,
        clamp_high: PV_CEIL, clamp_low: PV_FLOOR,
        slot_a: 16'h0000, slot_b: 16'h0000,
        scale_top: 16'h03e8, scale_bottom: 16'h0000,
        point_place: 2'h1, open_policy: POL_UP,
        knee: {16'h03e8, 16'h03e8, 16'h03e8},
        offs: {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
    };
endpackage

// ### tb/contact_panel.sv
// Purpose: far side of the meter: two dry contacts and a keypad operator
// Assumes: contact level 1 means closed, as the meter's pins expect
// Notes: no contact bounce modelled; the bench commands each position
`timescale 1ns/1ns

module contact_panel
(
    input wire logic close_a,
    input wire logic close_b,
    output logic contact_a,
    output logic contact_b,
    output logic [15:0] operator_code
);
    // Contacts follow the commanded position at once
    assign contact_a = close_a;
    assign contact_b = close_b;
    // code entered at prompt
    // Operator only knows the factory code, so a restore never locks it out
    assign operator_code = 16'h0000;
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for the meter settings block
// Assumes: one wait cycle per bus access, values in tenths of a percent
// Notes: extremes and display settle within three edges of a sample
`timescale 1ns/1ns

module testbench;
    import meter_pkg::*;
    logic clk_sys, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] pv_sample, quick_view_slot_a, quick_view_slot_b, operator_code;
    logic pv_valid, sensor_open, close_a, close_b, contact_a, contact_b;
    val_t display_value, control_value, lowest_value_hold, highest_value_hold;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    // Device under test
    meter_settings dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pv_sample(pv_sample), .pv_valid(pv_valid), .sensor_open(sensor_open),
        .contact_a(contact_a), .contact_b(contact_b), .display_value(display_value),
        .control_value(control_value), .lowest_value_hold(lowest_value_hold),
        .highest_value_hold(highest_value_hold), .quick_view_slot_a(quick_view_slot_a),
        .quick_view_slot_b(quick_view_slot_b));
    // Contacts and operator
    contact_panel panel (.close_a(close_a), .close_b(close_b), .contact_a(contact_a),
        .contact_b(contact_b), .operator_code(operator_code));

    // 250 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic signed [31:0] seen,
                         input logic signed [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, want, seen);
        end
    endtask

    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge so the next request never lands in the release step
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [6:0] a, input logic [31:0] want, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, want);
    endtask

    // One process sample, then time for display and extremes to follow
    task automatic pv(input logic [15:0] v);
        pv_sample <= v;
        pv_valid <= 1'b1;
        @(posedge clk_sys);
        pv_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    // Contact change, past the two sync flops
    task automatic contacts(input logic a, input logic b);
        close_a <= a;
        close_b <= b;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        rd(A_LOWEST, 32'h3e8, "lowest");
        rd(A_HIGHEST, 32'h0, "highest");
        rd(A_STATUS, 32'h0, "status");
        rd(7'h7c, 32'h0, "unmapped");
        wr(A_LOWEST, 32'h5);
        rd(A_LOWEST, 32'h3e8, "lowest ro");
    endtask

    task automatic t_track();
        // Mode off: open contacts must not clear
        contacts(1'b0, 1'b0);
        pv(16'h0190);
        pv(16'h00c8);
        pv(16'h02bc);
        check("lowest", lowest_value_hold, 200);
        check("highest", highest_value_hold, 700);
        pv(16'h04b0);
        check("display hi", display_value, 1050);
        check("control hi", control_value, 1200);
        check("highest cl", highest_value_hold, 1050);
        pv(16'hff9c);
        check("display lo", display_value, -50);
        check("control lo", control_value, -100);
        check("lowest cl", lowest_value_hold, -50);
        contacts(1'b1, 1'b1);
    endtask

    task automatic t_access();
        wr(A_CLAMP_HI, 32'd900);
        rd(A_CLAMP_HI, 32'd1050, "no grant");
        wr(A_PROMPT, 32'd5);
        rd(A_STATUS, 32'h0, "bad code");
        wr(A_PROMPT, {16'h0, operator_code});
        rd(A_STATUS, 32'h1, "granted");
        wr(A_CLAMP_HI, 32'd900);
        rd(A_CLAMP_HI, 32'd900, "clamp hi");
        wr(A_CLAMP_LO, 32'd900);
        rd(A_CLAMP_LO, 32'hffffffce, "clamp order");
        pv(16'h03b6);
        check("display", display_value, 900);
    endtask

    task automatic t_lock();
        wr(A_LOCK, 32'h1);
        rd(A_STATUS, 32'h5, "lock st");
        wr(A_CLAMP_HI, 32'd800);
        rd(A_CLAMP_HI, 32'd900, "locked");
        wr(A_LOCK, 32'h0);
        rd(A_LOCK, 32'h0, "unlock");
    endtask

    task automatic t_limits();
        wr(A_SLOT_A, 32'd1299);
        wr(A_SLOT_B, 32'd1300);
        rd(A_SLOT_B, 32'h0, "slot b");
        check("slot a", quick_view_slot_a, 1299);
        check("slot b out", quick_view_slot_b, 0);
        wr(A_KNEE0, 32'd1001);
        rd(A_KNEE0, 32'd1000, "knee");
        wr(A_SCALE_TOP, 32'd10000);
        rd(A_SCALE_TOP, 32'd1000, "scale");
        wr(A_POINT, 32'h3);
        rd(A_POINT, 32'h3, "point");
        sensor_open <= 1'b1;
        pv(16'h01f4);
        check("open up", control_value, 1000);
        wr(A_POLICY, 32'h2);
        pv(16'h01f4);
        check("open dn", control_value, 0);
        rd(A_STATUS, 32'h3, "open st");
        sensor_open <= 1'b0;
        wr(A_OFFS0, 32'hfffffc17);
        rd(A_OFFS0, 32'h0, "offs min");
        wr(A_OFFS0, 32'd100);
        pv(16'h0000);
        check("bias", control_value, 100);
        wr(A_OFFS0, 32'h0);
    endtask

    task automatic t_contacts();
        wr(A_MODE, 32'h3);
        rd(A_MODE, 32'h0, "mode 3");
        wr(A_MODE, 32'h1);
        pv(16'h012c);
        check("held lo", lowest_value_hold, -50);
        contacts(1'b0, 1'b1);
        check("clr lo", lowest_value_hold, 300);
        check("clr hi", highest_value_hold, 300);
        contacts(1'b1, 1'b1);
        pv(16'h0258);
        check("rec hi", highest_value_hold, 600);
        wr(A_MODE, 32'h2);
        contacts(1'b1, 1'b0);
        pv(16'h0064);
        check("m2 lo", lowest_value_hold, 100);
        check("m2 hi", highest_value_hold, 100);
        contacts(1'b1, 1'b1);
        pv(16'h01f4);
        check("m2 rec", highest_value_hold, 500);
        contacts(1'b0, 1'b1);
        check("m2 clr", lowest_value_hold, 500);
        contacts(1'b1, 1'b1);
    endtask

    task automatic t_restore();
        wr(A_RESTORE, 32'h1);
        rd(A_CLAMP_HI, 32'd1050, "rst clamp");
        rd(A_MODE, 32'h0, "rst mode");
        rd(A_POLICY, 32'h1, "rst policy");
        rd(A_RESTORE, 32'h0, "rst self");
    endtask

    task automatic t_power();
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check("pwr lo", lowest_value_hold, 1000);
        check("pwr hi", highest_value_hold, 0);
    endtask

    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        avs_address = 7'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        pv_sample = 16'h0000;
        pv_valid = 1'b0;
        sensor_open = 1'b0;
        close_a = 1'b1;
        close_b = 1'b1;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_track();
        t_access();
        t_lock();
        t_limits();
        t_contacts();
        t_restore();
        t_power();
        tally_and_finish();
    end
endmodule
